/* numeric_format_pkg.sv */
/*
  Constants and types shared by the numeric format unit and its pack and
  unpack converters.
  Assumes the users import the whole package and run on a single clock.
*/
package numeric_format_pkg;

  localparam int SP_W = 32;
  localparam int EXT_W = 40;
  localparam int SH_W = 16;
  localparam int EXP_W = 8;
  localparam int SP_FRAC_W = 23;
  localparam int EXT_FRAC_W = 31;
  localparam int SH_EXP_W = 4;
  localparam int SH_FRAC_W = 11;
  localparam int PROD_W = 64;
  localparam int ACC_W = 80;
  localparam int SP_SIGN_BIT = 31;
  localparam int EXT_SIGN_BIT = 39;
  localparam int SH_SIGN_BIT = 15;
  localparam int UNPACK_PAD_W = 12;

  localparam logic [7:0] EXP_BIAS = 8'h7F;
  localparam logic [7:0] EXP_ALL_ONES = 8'hFF;
  localparam logic [7:0] EXP_NORMAL_MAX = 8'hFE;
  localparam logic [7:0] PACK_OVF_ABOVE = 8'h87;
  localparam logic [7:0] PACK_NORM_MIN = 8'h78;
  localparam logic [7:0] PACK_DENORM_MIN = 8'h6E;
  localparam logic [7:0] PACK_DENORM_SHIFT_BASE = 8'h85;
  localparam logic [7:0] UNPACK_DENORM_EXP_BASE = 8'h78;
  localparam logic [14:0] SH_MAX_MAG = 15'h7FFF;

  localparam logic [39:0] RESULT_RESET = 40'h00_0000_0000;
  localparam logic [79:0] ACC_RESET = 80'h0000_0000_0000_0000_0000;

  typedef enum logic [3:0] {
    OP_CLASSIFY_SINGLE,
    OP_CLASSIFY_EXT,
    OP_PACK,
    OP_UNPACK,
    OP_MUL,
    OP_MAC_ADD,
    OP_MAC_SUB,
    OP_ACC_CLEAR,
    OP_ALU_ADD,
    OP_ALU_SUB
  } op_t;

  typedef enum logic [2:0] {
    CLASS_ZERO,
    CLASS_DENORMAL,
    CLASS_NORMAL,
    CLASS_INFINITY,
    CLASS_NAN
  } fp_class_t;

endpackage : numeric_format_pkg

/* pack_to_short_float.sv */
/*
  Combinational conversion of a 32-bit float to the 16-bit short float.
  Assumes the caller registers the result and the overflow indication.
*/
`timescale 1ns/10ps
`default_nettype none
module pack_to_short_float
  import numeric_format_pkg::*;
(
  input wire logic [31:0] src,
  output logic [15:0] packed_word,
  output logic overflow
);

  logic s;
  logic [7:0] e;
  logic [22:0] f;
  logic [24:0] t;
  logic [15:0] sum;

  always_comb begin
    s = src[SP_SIGN_BIT];
    e = src[30:23];
    f = src[22:0];
    t = 25'h0000000;
    sum = 16'h0000;
    packed_word = 16'h0000;
    overflow = 1'b0;
    if (e > PACK_OVF_ABOVE) begin
      packed_word = {s, SH_MAX_MAG};
      overflow = 1'b1;
    end else if (e >= PACK_NORM_MIN) begin
      sum = {1'b0, e[7], e[2:0], f[22:12]} + {15'h0000, f[11]};
      if (sum[15]) begin
        // A round-up past the top code still saturates.
        packed_word = {s, SH_MAX_MAG};
        overflow = 1'b1;
      end else begin
        packed_word = {s, sum[14:0]};
      end
    end else if (e >= PACK_DENORM_MIN) begin
      t = {1'b1, f, 1'b0} >> (PACK_DENORM_SHIFT_BASE - e);
      sum = {5'h00, t[11:1]} + {15'h0000, t[0]};
      packed_word = {s, sum[14:0]};
    end else begin
      packed_word = 16'h0000;
    end
  end

endmodule : pack_to_short_float
`default_nettype wire

/* unpack_short_float.sv */
/*
  Combinational conversion of a 16-bit short float to a 32-bit float.
  Assumes the short value sits in the low 16 bits of its source field.
*/
`timescale 1ns/10ps
`default_nettype none
module unpack_short_float
  import numeric_format_pkg::*;
(
  input wire logic [15:0] src,
  output logic [31:0] result
);

  logic [3:0] ex;
  logic [10:0] fr;
  logic [3:0] lz;
  logic found;
  logic [10:0] norm;

  always_comb begin
    ex = src[14:11];
    fr = src[10:0];
    lz = 4'h0;
    found = 1'b0;
    for (int i = SH_FRAC_W - 1; i >= 0; i--) begin
      if (!found) begin
        if (fr[i]) begin
          found = 1'b1;
        end else begin
          lz = lz + 4'h1;
        end
      end
    end
    norm = fr << (lz + 4'h1);
    if (ex != 4'h0) begin
      result = {src[SH_SIGN_BIT], ex[3], {4{~ex[3]}}, ex[2:0], fr,
                12'h000};
    end else if (fr == 11'h000) begin
      result = {src[SH_SIGN_BIT], 31'h00000000};
    end else begin
      result = {src[SH_SIGN_BIT], UNPACK_DENORM_EXP_BASE - {4'h0, lz},
                norm, 12'h000};
    end
  end

endmodule : unpack_short_float
`default_nettype wire

/* numeric_format_unit.sv */
/*
  Numeric format unit: float classification, short float pack and unpack,
  fixed-point multiply with an 80-bit accumulator and a 32-bit adder.
  Assumes the sequencer presents one operation per cycle with in_valid and
  takes every result one cycle later; there is no back-pressure.
*/
`timescale 1ns/10ps
`default_nettype none
module numeric_format_unit
  import numeric_format_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_valid,
  input wire logic [3:0] op,
  input wire logic [39:0] operand_a,
  input wire logic [31:0] operand_b,
  input wire logic a_signed,
  input wire logic b_signed,
  output logic out_valid_q,
  output logic [3:0] out_op_q,
  output logic [39:0] result_q,
  output logic [2:0] fp_class_q,
  output logic signed [8:0] true_exp_q,
  output logic [31:0] significand_q,
  output logic sign_q,
  output logic shifter_overflow_flag_q,
  output logic shifter_zero_flag_q,
  output logic shifter_sign_flag_q,
  output logic [63:0] product_q,
  output logic [79:0] acc_q
);

  op_t op_in;
  assign op_in = op_t'(op);

  // Classification shared by the single and extended layouts.

  function automatic fp_class_t classify(input logic [7:0] e,
                                         input logic frac_nz);
    fp_class_t c;
    c = CLASS_NORMAL;
    if (e == EXP_ALL_ONES) begin
      c = frac_nz ? CLASS_NAN : CLASS_INFINITY;
    end else if (e == 8'h00) begin
      c = frac_nz ? CLASS_DENORMAL : CLASS_ZERO;
    end else if (e <= EXP_NORMAL_MAX) begin
      c = CLASS_NORMAL;
    end
    return c;
  endfunction : classify

  logic sp_sign;
  logic [7:0] sp_exp;
  logic [22:0] sp_frac;
  logic ext_sign;
  logic [7:0] ext_exp;
  logic [30:0] ext_frac;

  // Field split of the two float layouts.
  assign sp_sign = operand_a[SP_SIGN_BIT];
  assign sp_exp = operand_a[30:23];
  assign sp_frac = operand_a[22:0];
  assign ext_sign = operand_a[EXT_SIGN_BIT];
  assign ext_exp = operand_a[38:31];
  assign ext_frac = operand_a[30:0];

  fp_class_t sp_class;
  fp_class_t ext_class;
  logic signed [8:0] sp_true_exp;
  logic signed [8:0] ext_true_exp;
  logic [31:0] sp_signif;
  logic [31:0] ext_signif;

  always_comb begin
    sp_class = classify(sp_exp, sp_frac != 23'h000000);
    ext_class = classify(ext_exp, ext_frac != 31'h00000000);
    sp_true_exp = $signed({1'b0, sp_exp}) - $signed({1'b0, EXP_BIAS});
    ext_true_exp = $signed({1'b0, ext_exp}) - $signed({1'b0, EXP_BIAS});
    // The hidden one is present only for normal values.
    sp_signif = {8'h00, sp_class == CLASS_NORMAL, sp_frac};
    ext_signif = {ext_class == CLASS_NORMAL, ext_frac};
  end

  // Short float converters; both settle within the same cycle.

  logic [15:0] packed_word;
  logic pack_ovf;
  logic [31:0] unpacked_word;

  pack_to_short_float u_pack (
    .src(operand_a[31:0]),
    .packed_word(packed_word),
    .overflow(pack_ovf)
  );

  unpack_short_float u_unpack (
    .src(operand_a[15:0]),
    .result(unpacked_word)
  );

  // Multiplier. Operands are widened by one bit so that an unsigned input
  // keeps its top bit as magnitude while the other may be signed.

  logic signed [32:0] mul_x;
  logic signed [32:0] mul_y;
  logic signed [65:0] mul_full;
  logic [63:0] product;
  logic prod_signed;
  logic [79:0] prod_ext;

  always_comb begin
    mul_x = $signed({a_signed & operand_a[31], operand_a[31:0]});
    mul_y = $signed({b_signed & operand_b[31], operand_b});
    mul_full = mul_x * mul_y;
    prod_signed = a_signed | b_signed;
    if (a_signed && b_signed) begin
      // Drops the redundant sign bit; for fractions this also restores
      // the binary point just left of the top magnitude bit.
      product = {mul_full[62:0], 1'b0};
    end else begin
      product = mul_full[63:0];
    end
    if (prod_signed) begin
      prod_ext = {{16{product[63]}}, product};
    end else begin
      prod_ext = {16'h0000, product};
    end
  end

  // Adder: result keeps the 32-bit operand width, wrapping on overflow.

  logic [31:0] alu_sum;
  logic [31:0] alu_diff;

  always_comb begin
    alu_sum = operand_a[31:0] + operand_b;
    alu_diff = operand_a[31:0] - operand_b;
  end

  // Result selection.

  logic [39:0] result_d;
  logic [2:0] class_d;
  logic signed [8:0] exp_d;
  logic [31:0] signif_d;
  logic sign_d;

  always_comb begin
    result_d = RESULT_RESET;
    class_d = CLASS_ZERO;
    exp_d = 9'sh000;
    signif_d = 32'h00000000;
    sign_d = 1'b0;
    case (op_in)
      OP_CLASSIFY_SINGLE: begin
        result_d = {8'h00, operand_a[31:0]};
        class_d = sp_class;
        exp_d = sp_true_exp;
        signif_d = sp_signif;
        sign_d = sp_sign;
      end
      OP_CLASSIFY_EXT: begin
        result_d = operand_a;
        class_d = ext_class;
        exp_d = ext_true_exp;
        signif_d = ext_signif;
        sign_d = ext_sign;
      end
      OP_PACK: begin
        result_d = {24'h000000, packed_word};
        sign_d = packed_word[SH_SIGN_BIT];
      end
      OP_UNPACK: begin
        result_d = {8'h00, unpacked_word};
        sign_d = unpacked_word[SP_SIGN_BIT];
      end
      OP_MUL, OP_MAC_ADD, OP_MAC_SUB: begin
        // The upper half is the most significant product for fractions.
        result_d = {8'h00, product[63:32]};
        sign_d = prod_signed & product[63];
      end
      OP_ALU_ADD: begin
        result_d = {8'h00, alu_sum};
        sign_d = alu_sum[31];
      end
      OP_ALU_SUB: begin
        result_d = {8'h00, alu_diff};
        sign_d = alu_diff[31];
      end
      default: begin
        result_d = RESULT_RESET;
      end
    endcase
  end

  // Output handshake: one result per accepted operation, one cycle later.

  always_ff @(posedge clk) begin
    if (!rstn) begin
      out_valid_q <= 1'b0;
      out_op_q <= 4'h0;
    end else begin
      out_valid_q <= in_valid;
      if (in_valid) begin
        out_op_q <= op;
      end
    end
  end

  // Result registers hold their value until the next accepted operation.

  always_ff @(posedge clk) begin
    if (!rstn) begin
      result_q <= RESULT_RESET;
      fp_class_q <= 3'h0;
      true_exp_q <= 9'sh000;
      significand_q <= 32'h00000000;
      sign_q <= 1'b0;
    end else if (in_valid) begin
      result_q <= result_d;
      fp_class_q <= class_d;
      true_exp_q <= exp_d;
      significand_q <= signif_d;
      sign_q <= sign_d;
    end
  end

  // Shifter condition flags change only on pack and unpack.

  always_ff @(posedge clk) begin
    if (!rstn) begin
      shifter_overflow_flag_q <= 1'b0;
      shifter_zero_flag_q <= 1'b0;
      shifter_sign_flag_q <= 1'b0;
    end else if (in_valid && op_in == OP_PACK) begin
      shifter_overflow_flag_q <= pack_ovf;
      shifter_zero_flag_q <= 1'b0;
      shifter_sign_flag_q <= 1'b0;
    end else if (in_valid && op_in == OP_UNPACK) begin
      shifter_overflow_flag_q <= 1'b0;
      shifter_zero_flag_q <= 1'b0;
      shifter_sign_flag_q <= 1'b0;
    end
  end

  // Product register follows every multiplier operation.

  always_ff @(posedge clk) begin
    if (!rstn) begin
      product_q <= 64'h0000_0000_0000_0000;
    end else if (in_valid && (op_in == OP_MUL || op_in == OP_MAC_ADD ||
                              op_in == OP_MAC_SUB)) begin
      product_q <= product;
    end
  end

  // Accumulator. Sixteen guard bits let many full-scale products sum
  // before the register wraps; wrap is not detected here.

  always_ff @(posedge clk) begin
    if (!rstn) begin
      acc_q <= ACC_RESET;
    end else if (in_valid) begin
      if (op_in == OP_ACC_CLEAR) begin
        acc_q <= ACC_RESET;
      end else if (op_in == OP_MAC_ADD) begin
        acc_q <= acc_q + prod_ext;
      end else if (op_in == OP_MAC_SUB) begin
        acc_q <= acc_q - prod_ext;
      end
    end
  end

endmodule : numeric_format_unit
`default_nettype wire

/* numeric_format_properties.sv */
/*
  Concurrent checks on the ports of the numeric format unit.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module numeric_format_properties
  import numeric_format_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_valid,
  input wire logic [3:0] op,
  input wire logic [39:0] operand_a,
  input wire logic out_valid_q,
  input wire logic [3:0] out_op_q,
  input wire logic [39:0] result_q,
  input wire logic shifter_overflow_flag_q,
  input wire logic shifter_zero_flag_q,
  input wire logic shifter_sign_flag_q,
  input wire logic [79:0] acc_q
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  logic [7:0] pexp;
  assign pexp = operand_a[30:23];
  sequence pack_req;
    in_valid && op == OP_PACK;
  endsequence
  sequence unpack_req;
    in_valid && op == OP_UNPACK;
  endsequence
  valid_latency_a: assert property (in_valid |=> out_valid_q)
    else $error("result pulse missing");
  idle_hold_a: assert property (!in_valid |=> !out_valid_q &&
    $stable(result_q) && $stable(acc_q)) else $error("idle cycle moved");
  op_echo_a: assert property (in_valid |=> out_op_q == $past(op))
    else $error("op echo wrong");
  pack_flags_a: assert property (pack_req |=>
    !shifter_zero_flag_q && !shifter_sign_flag_q) else $error("pack flags");
  unpack_flags_a: assert property (unpack_req |=> !shifter_zero_flag_q &&
    !shifter_sign_flag_q && !shifter_overflow_flag_q)
    else $error("unpack flags");
  pack_saturate_a: assert property (pack_req ##0 pexp > PACK_OVF_ABOVE |=>
    result_q[14:0] == SH_MAX_MAG && shifter_overflow_flag_q)
    else $error("no saturation");
  pack_no_ovf_a: assert property (pack_req ##0 (pexp >= PACK_DENORM_MIN &&
    pexp < PACK_OVF_ABOVE) |=> !shifter_overflow_flag_q)
    else $error("false overflow");
  pack_underflow_a: assert property (pack_req ##0 pexp < PACK_DENORM_MIN
    |=> result_q == 40'h0) else $error("tiny pack not zero");
  pack_sign_a: assert property (pack_req ##0 pexp >= PACK_DENORM_MIN |=>
    result_q[15] == $past(operand_a[31])) else $error("pack sign lost");
  unpack_sign_a: assert property (unpack_req |=>
    result_q[31] == $past(operand_a[15])) else $error("unpack sign lost");
endmodule : numeric_format_properties
`default_nettype wire

/* seq_model.sv */
/*
  Sequencer model: issues one operation to the unit at a falling edge.
  Assumes the unit answers one cycle after each accepted request.
*/
`timescale 1ns/10ps
`default_nettype none
module seq_model
  import numeric_format_pkg::*;
(
  input wire logic clk,
  output var logic in_valid,
  output var logic [3:0] op,
  output var logic [39:0] operand_a,
  output var logic [31:0] operand_b,
  output var logic a_signed,
  output var logic b_signed
);
  initial begin
    in_valid = 1'h0;
    op = 4'h0;
    operand_a = 40'h0;
    operand_b = 32'h0;
    a_signed = 1'h0;
    b_signed = 1'h0;
  end
  // Idle operands flip, so a unit that samples them while idle shows it.
  task automatic issue(input op_t o, input logic [39:0] a,
      input logic [31:0] b, input logic sa, input logic sb);
    @(negedge clk);
    in_valid = 1'h1;
    op = o;
    operand_a = a;
    operand_b = b;
    a_signed = sa;
    b_signed = sb;
    @(negedge clk);
    in_valid = 1'h0;
    operand_a = ~a;
    operand_b = ~b;
  endtask : issue
endmodule : seq_model
`default_nettype wire

/* test_numeric_format_unit.sv */
/*
  Self-checking bench for the numeric format unit.
  Assumes the sequencer model drives all operation inputs.
*/
`timescale 1ns/10ps
`default_nettype none
module test_numeric_format_unit
  import numeric_format_pkg::*;
;
  logic clk = 1'h0;
  logic rstn, in_valid, a_signed, b_signed, out_valid_q, sign_q, ov, zf, sf;
  logic [3:0] op, out_op_q;
  logic [39:0] operand_a, result_q;
  logic [31:0] operand_b, significand_q;
  logic [2:0] fp_class_q;
  logic signed [8:0] true_exp_q;
  logic [63:0] product_q;
  logic [79:0] acc_q;
  int errors = 0;
  int compares = 0;
  always #2 clk = ~clk;
  seq_model u_seq_model (.clk, .in_valid, .op, .operand_a, .operand_b,
    .a_signed, .b_signed);
  numeric_format_unit u_numeric_format_unit (.clk, .rstn, .in_valid, .op,
    .operand_a, .operand_b, .a_signed, .b_signed, .out_valid_q, .out_op_q,
    .result_q, .fp_class_q, .true_exp_q, .significand_q, .sign_q,
    .shifter_overflow_flag_q(ov), .shifter_zero_flag_q(zf),
    .shifter_sign_flag_q(sf), .product_q, .acc_q);
  task automatic check(input string what, input logic [79:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic go(input op_t o, input logic [39:0] a, input logic [31:0] b,
      input logic sa, input logic sb);
    u_seq_model.issue(o, a, b, sa, sb);
    check("valid", out_valid_q, 1'h1);
    check("op echo", out_op_q, o);
  endtask : go
  task automatic cl(input op_t o, input logic [39:0] a, input logic [2:0] c,
      input logic [8:0] te, input logic [31:0] sg);
    go(o, a, 32'h0, 1'h0, 1'h0);
    check("class", fp_class_q, c);
    check("true exp", {71'h0, true_exp_q}, te);
    check("significand", significand_q, sg);
  endtask : cl
  task automatic pk(input logic [31:0] a, input logic [15:0] w,
      input logic o);
    go(OP_PACK, {8'h0, a}, 32'h0, 1'h0, 1'h0);
    check("packed", result_q, {24'h0, w});
    check("overflow", ov, o);
    check("zero sign", {zf, sf}, 2'h0);
  endtask : pk
  task automatic up(input logic [15:0] a, input logic [31:0] w);
    go(OP_UNPACK, {24'h0, a}, 32'h0, 1'h0, 1'h0);
    check("unpacked", result_q, {8'h0, w});
    check("flags", {ov, zf, sf}, 3'h0);
  endtask : up
  task automatic ml(input op_t o, input logic [31:0] a, input logic [31:0] b,
      input logic sa, input logic sb, input logic [63:0] p);
    go(o, {8'h0, a}, b, sa, sb);
    check("product", product_q, p);
    check("product high", result_q, {8'h0, p[63:32]});
  endtask : ml
  task automatic t_reset;
    @(negedge clk);
    rstn = 1'h0;
    repeat (10) @(negedge clk);
    check("reset result", result_q, 80'h0);
    check("reset acc", acc_q, 80'h0);
    rstn = 1'h1;
    $display("t_reset done");
  endtask : t_reset
  task automatic t_classify;
    cl(OP_CLASSIFY_SINGLE, 40'h3F800000, CLASS_NORMAL, 9'h000, 32'h800000);
    cl(OP_CLASSIFY_SINGLE, 40'h7F7FFFFF, CLASS_NORMAL, 9'h07F, 32'hFFFFFF);
    cl(OP_CLASSIFY_SINGLE, 40'hFF800000, CLASS_INFINITY, 9'h080, 32'h0);
    cl(OP_CLASSIFY_SINGLE, 40'h7F800001, CLASS_NAN, 9'h080, 32'h1);
    cl(OP_CLASSIFY_SINGLE, 40'h80000000, CLASS_ZERO, 9'h181, 32'h0);
    cl(OP_CLASSIFY_EXT, 40'h3F80000001, CLASS_NORMAL, 9'h000, 32'h80000001);
    $display("t_classify done");
  endtask : t_classify
  task automatic t_pack;
    pk(32'h3F800000, 16'h3800, 1'h0);
    pk(32'hBF800800, 16'hB801, 1'h0);
    pk(32'h43800000, 16'h7800, 1'h0);
    pk(32'h44000000, 16'h7FFF, 1'h1);
    pk(32'hC7800000, 16'hFFFF, 1'h1);
    pk(32'h3C800000, 16'h0800, 1'h0);
    pk(32'h3B800000, 16'h0200, 1'h0);
    pk(32'h37000000, 16'h0001, 1'h0);
    pk(32'hB6800000, 16'h0000, 1'h0);
    $display("t_pack done");
  endtask : t_pack
  task automatic t_unpack;
    pk(32'h47800000, 16'h7FFF, 1'h1);
    up(16'h3800, 32'h3F800000);
    up(16'hF800, 32'hC3800000);
    up(16'h0801, 32'h3C801000);
    up(16'h0200, 32'h3B800000);
    up(16'h8001, 32'hB7000000);
    $display("t_unpack done");
  endtask : t_unpack
  task automatic t_mul;
    ml(OP_MUL, 32'hFFFFFFFF, 32'h2, 1'h0, 1'h0, 64'h1FFFFFFFE);
    ml(OP_MUL, 32'hFFFFFFFF, 32'h2, 1'h1, 1'h0, 64'hFFFFFFFFFFFFFFFE);
    ml(OP_MUL, 32'hFFFFFFFF, 32'h2, 1'h1, 1'h1, 64'hFFFFFFFFFFFFFFFC);
    ml(OP_MUL, 32'h40000000, 32'h40000000, 1'h1, 1'h1, 64'h2000000000000000);
    go(OP_ACC_CLEAR, 40'h0, 32'h0, 1'h0, 1'h0);
    check("acc clear", acc_q, 80'h0);
    repeat (2) ml(OP_MAC_ADD, 32'hFFFFFFFF, 32'hFFFFFFFF, 1'h0, 1'h0,
      64'hFFFFFFFE00000001);
    check("acc sum", acc_q, 80'h1FFFFFFFC00000002);
    ml(OP_MAC_SUB, 32'hFFFFFFFF, 32'h2, 1'h1, 1'h0, 64'hFFFFFFFFFFFFFFFE);
    check("acc diff", acc_q, 80'h1FFFFFFFC00000004);
    $display("t_mul done");
  endtask : t_mul
  task automatic t_alu;
    go(OP_ALU_ADD, 40'hFFFFFFFF, 32'h1, 1'h0, 1'h0);
    check("alu add", result_q, 80'h0);
    go(OP_ALU_SUB, 40'h0, 32'h1, 1'h0, 1'h0);
    check("alu sub", result_q, 80'hFFFFFFFF);
    $display("t_alu done");
  endtask : t_alu
  task automatic complete_run;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  initial begin
    rstn = 1'h0;
    t_reset;
    t_classify;
    t_pack;
    t_unpack;
    t_mul;
    t_alu;
    t_reset;
    complete_run;
  end
  // A hang would otherwise stall the run; it counts as a mismatch.
  initial begin
    #200000;
    errors++;
    complete_run;
  end
endmodule : test_numeric_format_unit
bind numeric_format_unit numeric_format_properties u_numeric_format_properties (
  .clk, .rstn, .in_valid, .op, .operand_a, .out_valid_q, .out_op_q,
  .result_q, .shifter_overflow_flag_q, .shifter_zero_flag_q,
  .shifter_sign_flag_q, .acc_q);
`default_nettype wire
